// ### hdl/rec_params.svh
// Constants for the regulator enable-control register bank.
// Included by the design module and by the testbench; definitions only.
`ifndef REC_PARAMS_SVH
`define REC_PARAMS_SVH

// Seven-bit target address on the two-wire bus.
// The value is arbitrary and not tied to any real part.
`define REC_TARGET_ADDR 7'h5a

// Register pointers.
`define REC_OFS_ENABLE_CONTROL 8'h00
`define REC_OFS_VOUT_SETTING 8'h01

// Field positions in enable_control.
`define REC_BIT_SW_ENABLE 0
`define REC_BIT_PIN_SELECT 1

// Power-on defaults: pin control selected, lowest output voltage.
`define REC_RST_ENABLE_CONTROL 8'h02
`define REC_RST_VOUT_SETTING 8'h00

// Output voltage code: 600 mV plus 5 mV per step, 1280 mV at the top.
`define REC_VOUT_BASE_MV 600
`define REC_VOUT_STEP_MV 5
`define REC_VOUT_TOP_MV 1280
`define REC_VOUT_MAX_CODE 8'h88

// Bits per byte on the wire.
`define REC_BYTE_BITS 4'h8

`endif

// ### hdl/rec_pkg.sv
// Types for the regulator enable-control register bank.
// Uses nothing from rec_params.svh; it includes no file.
package rec_pkg;

  // Software view of enable_control; upper bits are reserved.
  typedef struct packed {
    logic [5:0] reserved;
    logic pinSelect;
    logic swEnable;
  } rec_ctrl_t;

  // Two-wire target transaction phases.
  typedef enum logic [3:0] {
    REC_IDLE,
    REC_ADDR,
    REC_ADDR_ACK,
    REC_PTR,
    REC_PTR_ACK,
    REC_WDATA,
    REC_WDATA_ACK,
    REC_RDATA,
    REC_RDATA_ACK
  } rec_state_t;

endpackage

// ### hdl/rec_enable_ctrl.sv
// Regulator enable-control register bank behind a two-wire target port.
// Assumes scl, sda and the enable pin are asynchronous to clock, the bus
// is far slower than clock, and sys_rst is the power-on reset.
`timescale 1ns/1ps
`include "rec_params.svh"

module rec_enable_ctrl
  import rec_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOeN,
  input wire logic enablePin,
  output logic regulatorOn,
  output logic [7:0] voutCode
);

  // Synchronisers: stage 1 feeds stage 2 only; stage 3, on scl and sda only (the pin has two stages), is the edge history.
  logic [2:0] sclSync_reg;
  logic [2:0] sdaSync_reg;
  logic [1:0] pinSync_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclSync_reg <= 3'h7;
      sdaSync_reg <= 3'h7;
      pinSync_reg <= 2'h0;
    end else begin
      sclSync_reg <= {sclSync_reg[1:0], scl};
      sdaSync_reg <= {sdaSync_reg[1:0], sdaIn};
      pinSync_reg <= {pinSync_reg[0], enablePin};
    end
  end

  wire sclNow = sclSync_reg[1];
  wire sclOld = sclSync_reg[2];
  wire sdaNow = sdaSync_reg[1];
  wire sdaOld = sdaSync_reg[2];
  wire pinLevel = pinSync_reg[1];
  wire sclRise = sclNow & ~sclOld;
  wire sclFall = ~sclNow & sclOld;
  wire startSeen = sclNow & sclOld & sdaOld & ~sdaNow;
  wire stopSeen = sclNow & sclOld & ~sdaOld & sdaNow;

  rec_state_t state_reg;
  rec_state_t state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] bitCnt_reg;
  logic [3:0] bitCnt_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic readDir_reg;
  logic readDir_next;
  logic sdaLow_reg;
  logic sdaLow_next;
  logic masterAck_reg;
  logic masterAck_next;
  rec_ctrl_t ctrl_reg;
  rec_ctrl_t ctrl_next;
  logic [7:0] vout_reg;
  logic [7:0] vout_next;
  logic regOn_reg;

  // Register decode.
  wire byteDone = (bitCnt_reg == `REC_BYTE_BITS);
  wire addrMatch = (shift_reg[7:1] == `REC_TARGET_ADDR);
  wire hitCtrl = (ptr_reg == `REC_OFS_ENABLE_CONTROL);
  wire hitVout = (ptr_reg == `REC_OFS_VOUT_SETTING);
  // Unmapped pointers read as zero and swallow writes; they are still acked
  // so a block write that runs past the map does not stall the host.
  wire [7:0] readData = hitCtrl ? ctrl_reg :
                        hitVout ? vout_reg : 8'h00;
  // Codes above the top step would exceed 1.28 V, so they saturate.
  wire [7:0] voutClamped = (shift_reg > `REC_VOUT_MAX_CODE) ?
                           `REC_VOUT_MAX_CODE : shift_reg;
  wire rec_ctrl_t ctrlWritten = '{reserved: 6'h00,
                                  pinSelect: shift_reg[`REC_BIT_PIN_SELECT],
                                  swEnable: shift_reg[`REC_BIT_SW_ENABLE]};
  wire enableChoice = ctrl_reg.pinSelect ? pinLevel
                                         : ctrl_reg.swEnable;

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    ptr_next = ptr_reg;
    readDir_next = readDir_reg;
    sdaLow_next = sdaLow_reg;
    masterAck_next = masterAck_reg;
    ctrl_next = ctrl_reg;
    vout_next = vout_reg;
    if (startSeen) begin
      state_next = REC_ADDR;
      bitCnt_next = 4'h0;
      sdaLow_next = 1'b0;
    end else if (stopSeen) begin
      state_next = REC_IDLE;
      sdaLow_next = 1'b0;
    end else if (sclRise) begin
      case (state_reg)
        REC_ADDR, REC_PTR, REC_WDATA: begin
          shift_next = {shift_reg[6:0], sdaNow};
          bitCnt_next = bitCnt_reg + 4'h1;
        end
        REC_RDATA_ACK: masterAck_next = ~sdaNow;
        default: ;
      endcase
    end else if (sclFall) begin
      case (state_reg)
        REC_ADDR: begin
          if (byteDone) begin
            if (addrMatch) begin
              state_next = REC_ADDR_ACK;
              readDir_next = shift_reg[0];
              sdaLow_next = 1'b1;
            end else begin
              state_next = REC_IDLE;
            end
          end
        end
        REC_ADDR_ACK: begin
          if (readDir_reg) begin
            state_next = REC_RDATA;
            shift_next = readData;
            sdaLow_next = ~readData[7];
            bitCnt_next = 4'h1;
          end else begin
            state_next = REC_PTR;
            sdaLow_next = 1'b0;
            bitCnt_next = 4'h0;
          end
        end
        REC_PTR: begin
          if (byteDone) begin
            ptr_next = shift_reg;
            state_next = REC_PTR_ACK;
            sdaLow_next = 1'b1;
          end
        end
        REC_WDATA: begin
          if (byteDone) begin
            if (hitCtrl) begin
              ctrl_next = ctrlWritten;
            end
            if (hitVout) begin
              vout_next = voutClamped;
            end
            state_next = REC_WDATA_ACK;
            sdaLow_next = 1'b1;
          end
        end
        REC_PTR_ACK, REC_WDATA_ACK: begin
          if (state_reg == REC_WDATA_ACK) begin
            ptr_next = ptr_reg + 8'h01;
          end
          state_next = REC_WDATA;
          sdaLow_next = 1'b0;
          bitCnt_next = 4'h0;
        end
        REC_RDATA: begin
          if (byteDone) begin
            state_next = REC_RDATA_ACK;
            sdaLow_next = 1'b0;
            ptr_next = ptr_reg + 8'h01;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            sdaLow_next = ~shift_reg[6];
            bitCnt_next = bitCnt_reg + 4'h1;
          end
        end
        REC_RDATA_ACK: begin
          if (masterAck_reg) begin
            state_next = REC_RDATA;
            shift_next = readData;
            sdaLow_next = ~readData[7];
            bitCnt_next = 4'h1;
          end else begin
            state_next = REC_IDLE;
          end
        end
        default: state_next = REC_IDLE;
      endcase
    end
  end

  // Only power-on reset clears the bank; nothing survives it.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= REC_IDLE;
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      ptr_reg <= 8'h00;
      readDir_reg <= 1'b0;
      sdaLow_reg <= 1'b0;
      masterAck_reg <= 1'b0;
      ctrl_reg <= `REC_RST_ENABLE_CONTROL;
      vout_reg <= `REC_RST_VOUT_SETTING;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      ptr_reg <= ptr_next;
      readDir_reg <= readDir_next;
      sdaLow_reg <= sdaLow_next;
      masterAck_reg <= masterAck_next;
      ctrl_reg <= ctrl_next;
      vout_reg <= vout_next;
    end
  end

  // The regulator sees the voltage code continuously, so a host that
  // changes it while enabled gets a live step; disabling first avoids it.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regOn_reg <= 1'b0;
      sdaOeN <= 1'b1;
      voutCode <= `REC_RST_VOUT_SETTING;
    end else begin
      regOn_reg <= enableChoice;
      sdaOeN <= ~sdaLow_next;
      voutCode <= vout_next;
    end
  end

  assign regulatorOn = regOn_reg;

endmodule

// ### tb/rec_checker.sv
// Port checks for the regulator enable-control bank.
// Bound to rec_enable_ctrl; sees only its ports.
`timescale 1ns/1ps
module rec_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOeN,
  input wire logic enablePin,
  input wire logic regulatorOn,
  input wire logic [7:0] voutCode
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  reset_defaults_a: assert property (
    $past(sys_rst) |-> !regulatorOn && voutCode == 8'h00)
    else $error("outputs not at defaults after reset");
  bus_release_a: assert property ($past(sys_rst) |-> sdaOeN)
    else $error("data pin driven after reset");
  vout_range_a: assert property (voutCode <= 8'h88)
    else $error("voltage code above top step");
  vout_cause_a: assert property ($changed(voutCode) |->
    !$past(scl) || $past(sys_rst))
    else $error("voltage code moved without a bus write");
  sda_hold_a: assert property (scl && $past(scl) |-> $stable(sdaOeN))
    else $error("data pin moved while bus clock high");
  on_cause_a: assert property ($rose(regulatorOn) |->
    $past(enablePin, 3) || !$past(scl, 2) || $past(sys_rst))
    else $error("regulator turned on without a cause");
  off_cause_a: assert property ($fell(regulatorOn) |->
    !$past(enablePin, 3) || !$past(scl, 2) || $past(sys_rst))
    else $error("regulator turned off without a cause");
endmodule
bind rec_enable_ctrl rec_checker chk_u (.clock(clock), .sys_rst(sys_rst),
  .scl(scl), .sdaIn(sdaIn), .sdaOeN(sdaOeN), .enablePin(enablePin),
  .regulatorOn(regulatorOn), .voutCode(voutCode));

// ### tb/rec_i2c_master.sv
// Two-wire bus master standing in for the host controller.
// The data wire has a pull-up: it is low when either side pulls it.
`timescale 1ns/1ps
module rec_i2c_master (
  input wire logic clock,
  input wire logic sdaOeN,
  output logic scl,
  output logic sdaIn
);
  logic sdaDrv;
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  assign sdaIn = sdaDrv & sdaOeN;
  // The clock line moves first and data four cycles later, so data
  // never changes close to a clock edge.
  task automatic ph(input logic c, input logic d);
    @(posedge clock);
    scl <= c;
    repeat (4) @(posedge clock);
    sdaDrv <= d;
    repeat (3) @(posedge clock);
  endtask
  task automatic xb(input logic [7:0] d, input logic a,
                    output logic [7:0] q, output logic n);
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, d[i]);
      ph(1'b1, d[i]);
      q[i] = sdaIn;
    end
    ph(1'b0, a);
    ph(1'b1, a);
    n = sdaIn;
  endtask
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  task automatic wr(input logic [6:0] ad, input logic [7:0] p,
                    input logic [7:0] d, output logic [2:0] nk);
    logic [7:0] q;
    ph(1'b1, 1'b0);
    xb({ad, 1'b0}, 1'b1, q, nk[2]);
    xb(p, 1'b1, q, nk[1]);
    xb(d, 1'b1, q, nk[0]);
    stop();
  endtask
  task automatic rd(input logic [6:0] ad, input logic [7:0] p,
                    output logic [7:0] d, output logic [2:0] nk);
    logic n;
    ph(1'b1, 1'b0);
    xb({ad, 1'b0}, 1'b1, d, nk[2]);
    xb(p, 1'b1, d, nk[1]);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    xb({ad, 1'b1}, 1'b1, d, nk[0]);
    xb(8'hff, 1'b1, d, n);
    stop();
  endtask
  // Two bytes from pointer zero, then both read back in one transfer with
  // an ack between them, so the pointer has to step on every byte.
  task automatic burst(input logic [6:0] ad, input logic [7:0] d0,
                       input logic [7:0] d1, output logic [15:0] q,
                       output logic [3:0] nk);
    logic [7:0] t;
    logic n;
    ph(1'b1, 1'b0);
    xb({ad, 1'b0}, 1'b1, t, nk[3]);
    xb(8'h00, 1'b1, t, nk[2]);
    xb(d0, 1'b1, t, nk[1]);
    xb(d1, 1'b1, t, nk[0]);
    stop();
    ph(1'b1, 1'b0);
    xb({ad, 1'b0}, 1'b1, t, n);
    xb(8'h00, 1'b1, t, n);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    xb({ad, 1'b1}, 1'b1, t, n);
    xb(8'hff, 1'b0, q[15:8], n);
    xb(8'hff, 1'b1, q[7:0], n);
    stop();
  endtask
endmodule

// ### tb/tb_regulator_enable_control.sv
// Self-checking bench for the regulator enable-control bank.
// The bench drives reset and the enable pin; the master drives the bus.
`timescale 1ns/1ps
`include "rec_params.svh"
module tb_regulator_enable_control;
  logic clock, sys_rst, enablePin, scl, sdaIn, sdaOeN, regulatorOn;
  logic [7:0] voutCode, got;
  logic [31:0] seed = 32'hc769;
  logic [2:0] nk;
  logic [3:0] nk4;
  logic [15:0] wide;
  logic [7:0] ctrl = 8'h02, vout = 8'h00;
  int failCount = 0, checksDone = 0;
  rec_enable_ctrl dut_u (.clock(clock), .sys_rst(sys_rst), .scl(scl),
    .sdaIn(sdaIn), .sdaOeN(sdaOeN), .enablePin(enablePin),
    .regulatorOn(regulatorOn), .voutCode(voutCode));
  rec_i2c_master m_u (.clock(clock), .sdaOeN(sdaOeN), .scl(scl),
    .sdaIn(sdaIn));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic cmp(input string n, input logic [7:0] e,
                     input logic [7:0] s);
    checksDone++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      failCount++;
    end
  endtask
  task automatic finishTest();
    if (failCount == 0 && checksDone > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic pin(input logic v);
    @(posedge clock);
    enablePin <= v;
    repeat (6) @(posedge clock);
    cmp("regulatorOn", {7'h0, ctrl[1] ? v : ctrl[0]},
        {7'h0, regulatorOn});
  endtask
  task automatic get(input logic [7:0] p);
    m_u.rd(`REC_TARGET_ADDR, p, got, nk);
    cmp("read acks", 8'h00, {5'h0, nk});
    cmp("read data", p == 8'h00 ? ctrl : (p == 8'h01 ? vout : 8'h00),
        got);
  endtask
  task automatic put(input logic [7:0] p, input logic [7:0] d);
    m_u.wr(`REC_TARGET_ADDR, p, d, nk);
    cmp("write acks", 8'h00, {5'h0, nk});
    if (p == 8'h00) ctrl = d & 8'h03;
    if (p == 8'h01) vout = d > 8'h88 ? 8'h88 : d;
    cmp("voutCode", vout, voutCode);
    get(p);
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    failCount++;
    finishTest();
  end
  initial begin
    sys_rst <= 1'b1;
    enablePin <= 1'b0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clock);
    cmp("voutCode", 8'h00, voutCode);
    get(8'h00);
    put(8'h01, 8'h88);
    pin(1'b1);
    pin(1'b0);
    put(8'h01, 8'h89);
    put(8'h05, 8'h33);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      put(8'h00, {seed[7:2], i[1:0]});
      pin(seed[8]);
      pin(!seed[8]);
      put(8'h01, seed[15:8]);
    end
    seed = xs(seed);
    m_u.burst(`REC_TARGET_ADDR, seed[7:0], seed[15:8], wide, nk4);
    ctrl = seed[7:0] & 8'h03;
    vout = seed[15:8] > 8'h88 ? 8'h88 : seed[15:8];
    cmp("burst acks", 8'h00, {4'h0, nk4});
    cmp("burst ctrl", ctrl, wide[15:8]);
    cmp("burst vout", vout, wide[7:0]);
    cmp("voutCode", vout, voutCode);
    m_u.wr(`REC_TARGET_ADDR ^ 7'h01, 8'h01, 8'h10, nk);
    cmp("stranger ack", 8'h01, {7'h0, nk[2]});
    get(8'h01);
    put(8'h01, 8'h40);
    put(8'h00, 8'h00);
    pin(1'b1);
    @(posedge clock);
    sys_rst <= 1'b1;
    enablePin <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    ctrl = 8'h02;
    vout = 8'h00;
    repeat (6) @(posedge clock);
    cmp("voutCode", 8'h00, voutCode);
    cmp("regulatorOn", 8'h01, {7'h0, regulatorOn});
    get(8'h00);
    finishTest();
  end
endmodule
